//--- core/sdr_pkg.sv
// package for the steering diagnostic readout block
package sdr_pkg;

    // --------------------------------------------------------------
    // selector codes
    // --------------------------------------------------------------
    localparam logic [3:0] SEL_ACQUIRE = 4'h0;
    localparam logic [3:0] SEL_IDLE_TEST = 4'hA;
    localparam logic [3:0] SEL_ALARM_HOLD = 4'hB;
    localparam logic [3:0] SEL_FINE_ROUTE = 4'hC;
    localparam logic [3:0] SEL_SECOND_WIPER = 4'hD;
    localparam logic [3:0] SEL_ALARM_KEY = 4'hE;
    localparam logic [3:0] SEL_DEFAULT = 4'hF;

    // --------------------------------------------------------------
    // register map (word indices times four)
    // --------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LIMITS = 8'h04;
    localparam logic [7:0] ADDR_THRESH = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_SLOPE = 8'h10;
    localparam logic [7:0] ADDR_ANGLE = 8'h14;
    localparam logic [7:0] ADDR_CAPTURE = 8'h18;
    localparam logic [7:0] ADDR_REVS = 8'h1C;
    localparam logic [7:0] ADDR_FLUX = 8'h20;
    localparam logic [7:0] ADDR_QUAD = 8'h24;

    // ctrl field positions
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_SAVE_BIT = 4;
    localparam int CTRL_CHOICE_LSB = 5;
    localparam int CTRL_LIMOPT_BIT = 8;
    localparam int CTRL_BUS_BIT = 9;
    localparam int CTRL_FINE_BIT = 10;
    localparam int CTRL_ACQDONE_BIT = 11;
    localparam int CTRL_CENTER_BIT = 12;
    localparam int CTRL_ONEHOT_BIT = 13;
    localparam int CTRL_COARSE1_LSB = 16;
    localparam int CTRL_COARSE2_LSB = 20;

    localparam logic [31:0] CTRL_RESET = 32'h0000_000F;
    localparam logic [3:0] COARSE_OFF = 4'h9;

    // --------------------------------------------------------------
    // quadrant codes: 10-bit counts of a 5 V range
    // --------------------------------------------------------------
    localparam logic [9:0] QUAD_0_90 = 10'h281;
    localparam logic [9:0] QUAD_90_180 = 10'h384;
    localparam logic [9:0] QUAD_M180_M90 = 10'h07F;
    localparam logic [9:0] QUAD_M90_0 = 10'h181;

    // --------------------------------------------------------------
    // slope monitor
    // --------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int SLOPE_MS = 16;
    localparam int SLOPE_CYCLES = SLOPE_MS * 1000 * CLK_MHZ;
    localparam logic [10:0] JERK_LIMIT = 11'h03D;
    localparam logic [10:0] CMD_BASE = 11'h03D;
    localparam logic [10:0] CMD_STEP = 11'h012;
    localparam logic [10:0] CMD_TOP = 11'h19A;
    localparam logic [3:0] CMD_TOP_LEVEL = 4'h9;

    // encoder counts scaled: 2^5 counts is one reading count
    localparam int REV_SHIFT = 5;

    typedef struct packed {
        logic [9:0] primary;
        logic [9:0] secondary;
        logic [9:0] feedback;
        logic [9:0] fine;
    } sdr_adc_t;

    typedef struct packed {
        logic stuck;
        logic pot_stuck;
        logic stall;
        logic mismatch;
    } sdr_alarm_t;

endpackage : sdr_pkg

//--- core/sdr_readout.sv
// steering diagnostic readout: selector decode and status readings
//
// Functional notes
// - selector 0 acquires offsets, then reverts 15
// - selector 10 runs idle test until saved
// - selector 11 masks stuck, stall alarms; mismatch too with bit 13 set
// - selector 12 reads set point from fine input
// - selector 13 reads secondary command wiper
// - selector 14 masks alarms until key cycle
// - 15 default; 1 to 9 have no effect
// - quadrant reading encodes sector as fixed voltage
// - flux frequency between nominal and 1.33 times
// - end switch reads on while pin low
// - upper limit flag above upper limit
// - lower limit flag below lower limit
// - centering flag on during auto centering
// - wheel angle zeroed at straight-ahead edge
// - slope source chosen by selector value
// - slope is difference of samples 16 ms apart
// - one count is 5/1024 V per interval
// - feedback jerk alarm above 61 counts
// - choice 3 captures pot at first falling edge
// - choice 4 counts encoder between falling edges
// - travel demand from pin or bus setting
// - fine conversion flag on with fine input
// - command fault threshold from 0-9 level
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
module sdr_readout
    import sdr_pkg::*;
#(
    parameter int SLOPE_TICKS = sdr_pkg::SLOPE_CYCLES
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // converter samples and motor side inputs
    input wire sdr_pkg::sdr_adc_t adc,
    input wire sdr_pkg::sdr_alarm_t alarm_raw,
    input wire logic [15:0] nominal_saturation_frequency,
    input wire logic [7:0] flux_level,
    input wire logic [9:0] feedback_position_reading,
    input wire logic [9:0] upper_limit,
    input wire logic [9:0] lower_limit,
    input wire logic [1:0] sector,
    input wire logic [9:0] expected_pot_at_center,
    input wire logic key_on,
    input wire logic bus_travel,
    // pins
    input wire logic cw_pin_n,
    input wire logic ccw_pin_n,
    input wire logic straight_ahead_switch,
    input wire logic travel_pin,
    input wire logic enc_step,
    input wire logic enc_dir,
    // outputs
    output sdr_pkg::sdr_alarm_t alarm_out,
    output logic idle_test_active,
    output logic acquire_active,
    output logic [9:0] set_point_reading,
    output logic feedback_pot_jerk_alarm,
    output logic command_pot_fault_alarm,
    output logic mismatch_hint
);
    import sdr_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [6:0] pin_s1_reg;
    logic [6:0] pin_s2_reg;
    logic [6:0] pins_in;
    assign pins_in = {travel_pin, enc_dir, enc_step, straight_ahead_switch,
                      ccw_pin_n, cw_pin_n, key_on};
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            // idle pin levels, so leaving reset makes no false edge
            pin_s1_reg <= 7'h0F;
            pin_s2_reg <= 7'h0F;
        end
        else
        begin
            pin_s1_reg <= pins_in;
            pin_s2_reg <= pin_s1_reg;
        end
    end
    wire key_s = pin_s2_reg[0];
    wire cw_n_s = pin_s2_reg[1];
    wire ccw_n_s = pin_s2_reg[2];
    wire sw_s = pin_s2_reg[3];
    wire step_s = pin_s2_reg[4];
    wire dir_s = pin_s2_reg[5];
    wire travel_s = pin_s2_reg[6];

    logic key_d_reg;
    logic sw_d_reg;
    logic step_d_reg;
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            key_d_reg <= 1'b1;
            sw_d_reg <= 1'b1;
            step_d_reg <= 1'b0;
        end
        else
        begin
            key_d_reg <= key_s;
            sw_d_reg <= sw_s;
            step_d_reg <= step_s;
        end
    end
    wire key_rise = key_s & ~key_d_reg;
    wire sw_fall = sw_d_reg & ~sw_s;
    wire sw_edge = sw_d_reg ^ sw_s;
    wire step_rise = step_s & ~step_d_reg;

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic idle_reg;
    wire wr_ctrl = wr && (addr == ADDR_CTRL);
    wire [3:0] sel = ctrl_reg[CTRL_SEL_LSB +: 4];
    wire [2:0] choice = ctrl_reg[CTRL_CHOICE_LSB +: 3];
    wire [3:0] coarse1 = ctrl_reg[CTRL_COARSE1_LSB +: 4];
    wire [3:0] coarse2 = ctrl_reg[CTRL_COARSE2_LSB +: 4];
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl)
            ctrl_next = wdata;
        if (sel == SEL_ACQUIRE && wr && addr == ADDR_LIMITS)
            ctrl_next[CTRL_SEL_LSB +: 4] = SEL_DEFAULT;
        if (sel == SEL_ALARM_KEY && key_rise)
            ctrl_next[CTRL_SEL_LSB +: 4] = SEL_DEFAULT;
        ctrl_next[CTRL_SAVE_BIT] = 1'b0;
        ctrl_next[CTRL_ACQDONE_BIT] = 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            ctrl_reg <= CTRL_RESET;
        else
            ctrl_reg <= ctrl_next;
    end

    // idle test held until 15 is saved
    always_ff @(posedge mclk)
    begin
        if (srst)
            idle_reg <= 1'b0;
        else if (sel == SEL_IDLE_TEST)
            idle_reg <= 1'b1;
        else if (sel == SEL_DEFAULT && wr_ctrl && wdata[CTRL_SAVE_BIT])
            idle_reg <= 1'b0;
    end
    assign idle_test_active = idle_reg;
    // acquisition request while selector is 0
    assign acquire_active = (sel == SEL_ACQUIRE);

    // ----------------------------------------------------------------
    // alarm masking and routing
    // ----------------------------------------------------------------
    // only listed codes act; 1..9 fall through
    wire mask_hold = (sel == SEL_ALARM_HOLD);
    wire mask_key = (sel == SEL_ALARM_KEY);
    wire toggle_cfg = ctrl_reg[CTRL_ONEHOT_BIT];
    // stuck and stall masked at 11; mismatch too when bit 13 is set
    // pot stuck and stall masked at 14; mismatch too when bit 13 is set
    assign alarm_out.stuck = alarm_raw.stuck & ~mask_hold;
    assign alarm_out.pot_stuck = alarm_raw.pot_stuck & ~mask_key;
    assign alarm_out.stall = alarm_raw.stall & ~(mask_hold | mask_key);
    assign alarm_out.mismatch = alarm_raw.mismatch
        & ~((mask_hold | mask_key) & toggle_cfg);

    // fine input route; secondary wiper route
    wire fine_sel = (sel == SEL_FINE_ROUTE);
    wire [9:0] sp_src = fine_sel ? adc.fine
        : (sel == SEL_SECOND_WIPER) ? adc.secondary : adc.primary;
    logic [9:0] sp_reg;
    always_ff @(posedge mclk)
    begin
        if (srst)
            sp_reg <= 10'h000;
        else
            sp_reg <= sp_src;
    end
    assign set_point_reading = sp_reg;
    // fine flag from route or setting
    wire fine_flag = fine_sel | ctrl_reg[CTRL_FINE_BIT];

    // ----------------------------------------------------------------
    // slope monitor
    // ----------------------------------------------------------------
    function automatic logic [10:0] mag(input logic [10:0] d);
        mag = d[10] ? 11'(-d) : d;
    endfunction : mag

    wire [9:0] slope_src = fine_sel ? adc.secondary
        : (sel == SEL_SECOND_WIPER) ? adc.feedback : adc.primary;
    logic [31:0] tick_reg;
    logic [9:0] prev_src_reg;
    logic [9:0] prev_fb_reg;
    logic [9:0] prev_sec_reg;
    logic [9:0] prev_pri_reg;
    logic [10:0] slope_reg;
    logic [10:0] peak_reg;
    logic jerk_reg;
    logic cmd_fault_reg;
    wire tick = (tick_reg == 32'(SLOPE_TICKS - 1));
    wire peak_clr = rd && (addr == ADDR_SLOPE);
    wire [10:0] d_src = 11'({1'b0, slope_src}) - 11'({1'b0, prev_src_reg});
    wire [10:0] d_fb = 11'({1'b0, adc.feedback}) - 11'({1'b0, prev_fb_reg});
    // own history, so a selector change raises no false command fault
    wire [10:0] d_pri = 11'({1'b0, adc.primary}) - 11'({1'b0, prev_pri_reg});
    wire [10:0] d_sec = 11'({1'b0, adc.secondary})
        - 11'({1'b0, prev_sec_reg});
    wire [3:0] cmd_level = wdata[3:0];
    logic [3:0] cmd_level_reg;
    wire [10:0] cmd_limit = (cmd_level_reg >= CMD_TOP_LEVEL) ? CMD_TOP
        : 11'(CMD_BASE + CMD_STEP * 11'(cmd_level_reg));

    always_ff @(posedge mclk)
    begin
        if (srst)
            cmd_level_reg <= CMD_TOP_LEVEL;
        else if (wr && addr == ADDR_THRESH)
            cmd_level_reg <= cmd_level;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            tick_reg <= 32'h0000_0000;
            prev_src_reg <= 10'h000;
            prev_fb_reg <= 10'h000;
            prev_sec_reg <= 10'h000;
            prev_pri_reg <= 10'h000;
            slope_reg <= 11'h000;
            peak_reg <= 11'h000;
            jerk_reg <= 1'b0;
            cmd_fault_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= tick ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
            if (peak_clr)
                peak_reg <= 11'h000;
            if (tick)
            begin
                prev_src_reg <= slope_src;
                prev_pri_reg <= adc.primary;
                prev_fb_reg <= adc.feedback;
                prev_sec_reg <= adc.secondary;
                slope_reg <= d_src;
                // a fresh sample wins over a read clear
                if (peak_clr || mag(d_src) > peak_reg)
                    peak_reg <= mag(d_src);
                // fixed jerk limit on feedback pot
                jerk_reg <= (mag(d_fb) > JERK_LIMIT);
                cmd_fault_reg <= (sel != SEL_FINE_ROUTE
                    && sel != SEL_SECOND_WIPER
                    && mag(d_pri) > cmd_limit)
                    || (mag(d_sec) > cmd_limit);
            end
        end
    end
    assign feedback_pot_jerk_alarm = jerk_reg;
    assign command_pot_fault_alarm = cmd_fault_reg;

    // ----------------------------------------------------------------
    // angle, limits, capture and revolution count
    // ----------------------------------------------------------------
    // limitation enable by sensor choice
    wire lim_en = (choice == 3'd4)
        ? ((coarse1 < COARSE_OFF) || (coarse2 < COARSE_OFF))
        : ctrl_reg[CTRL_LIMOPT_BIT];
    wire upper_limit_flag = lim_en && (feedback_position_reading > upper_limit);
    wire lower_limit_flag = lim_en && (feedback_position_reading < lower_limit);

    logic [15:0] angle_reg;
    logic [15:0] rev_cnt_reg;
    logic [15:0] revs_reg;
    logic [9:0] capture_reg;
    logic captured_reg;
    logic rev_armed_reg;
    wire [15:0] step_delta = dir_s ? 16'hFFFF : 16'h0001;
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            angle_reg <= 16'h0000;
            rev_cnt_reg <= 16'h0000;
            revs_reg <= 16'h0000;
            capture_reg <= 10'h000;
            captured_reg <= 1'b0;
            rev_armed_reg <= 1'b0;
        end
        else
        begin
            if (sw_edge)
                angle_reg <= 16'h0000;
            else if (step_rise)
                angle_reg <= angle_reg + step_delta;
            if (choice == 3'd3 && sw_fall && !captured_reg)
            begin
                capture_reg <= adc.feedback;
                captured_reg <= 1'b1;
            end
            if (choice == 3'd4 && sw_fall)
            begin
                if (rev_armed_reg)
                    revs_reg <= rev_cnt_reg;
                rev_armed_reg <= 1'b1;
                rev_cnt_reg <= 16'h0000;
            end
            else if (step_rise)
                rev_cnt_reg <= rev_cnt_reg + step_delta;
        end
    end
    assign mismatch_hint = captured_reg
        && (capture_reg != expected_pot_at_center);

    // ----------------------------------------------------------------
    // readings and read port
    // ----------------------------------------------------------------
    // sector code
    wire [9:0] quad = (sector == 2'd0) ? QUAD_0_90
        : (sector == 2'd1) ? QUAD_90_180
        : (sector == 2'd2) ? QUAD_M180_M90 : QUAD_M90_0;
    // nominal plus up to a third as flux drops
    wire [23:0] flux_prod = 24'(nominal_saturation_frequency)
        * 24'(8'hFF - flux_level);
    wire [17:0] flux_freq = 18'(nominal_saturation_frequency)
        + 18'(flux_prod / 24'd765);
    wire cw_end_switch_state = ~cw_n_s;
    wire ccw_end_switch_state = ~ccw_n_s;
    wire centering_active_flag = ctrl_reg[CTRL_CENTER_BIT];
    wire travel_demand_state = ctrl_reg[CTRL_BUS_BIT] ? bus_travel : travel_s;
    wire [15:0] counts_per_revolution = 16'(revs_reg >> REV_SHIFT);

    wire [31:0] status = {23'h0, fine_flag, travel_demand_state,
        centering_active_flag, lower_limit_flag, upper_limit_flag,
        ccw_end_switch_state, cw_end_switch_state, jerk_reg, cmd_fault_reg};
    logic [31:0] rsel;
    always_comb
    begin
        unique case (addr)
            ADDR_CTRL: rsel = ctrl_reg;
            ADDR_THRESH: rsel = {28'h0, cmd_level_reg};
            ADDR_STATUS: rsel = status;
            ADDR_SLOPE: rsel = {5'h0, peak_reg, 5'h0, slope_reg};
            ADDR_ANGLE: rsel = {16'h0, angle_reg};
            ADDR_CAPTURE: rsel = {22'h0, capture_reg};
            ADDR_REVS: rsel = {16'h0, counts_per_revolution};
            ADDR_FLUX: rsel = {14'h0, flux_freq};
            ADDR_QUAD: rsel = {22'h0, quad};
            default: rsel = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge mclk)
    begin
        if (srst)
            rdata <= 32'h0000_0000;
        else
            rdata <= rd ? rsel : 32'h0000_0000;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_hold_mask: assert property (@(posedge mclk) disable iff (srst)
        (sel == SEL_ALARM_HOLD) |-> !alarm_out.stuck && !alarm_out.stall)
        else $error("alarm not masked at selector 11");
    a_key_revert: assert property (@(posedge mclk) disable iff (srst)
        (sel == SEL_ALARM_KEY && key_rise) |=> (sel == SEL_DEFAULT))
        else $error("selector 14 did not revert on key");
    a_sp_route: assert property (@(posedge mclk) disable iff (srst)
        (sel == SEL_SECOND_WIPER) |=> set_point_reading == $past(adc.secondary))
        else $error("set point not from secondary wiper");
    a_idle_hold: assert property (@(posedge mclk) disable iff (srst)
        (idle_test_active && !(wr_ctrl && wdata[CTRL_SAVE_BIT]))
        |=> idle_test_active)
        else $error("idle test dropped without save");
    a_jerk_flag: assert property (@(posedge mclk) disable iff (srst)
        tick |=> jerk_reg == (mag($past(d_fb)) > 11'h03D))
        else $error("jerk flag wrong");
    a_end_switch: assert property (@(posedge mclk) disable iff (srst)
        !cw_pin_n [*3] |-> cw_end_switch_state)
        else $error("cw switch not on");
    a_angle_zero: assert property (@(posedge mclk) disable iff (srst)
        sw_edge |=> angle_reg == 16'h0000)
        else $error("angle not zeroed");
    a_fine_flag: assert property (@(posedge mclk) disable iff (srst)
        (sel == SEL_FINE_ROUTE) |-> status[8])
        else $error("fine flag off");
    a_read_zero: assert property (@(posedge mclk) disable iff (srst)
        !rd |=> rdata == 32'h0000_0000)
        else $error("read data outside read");

endmodule : sdr_readout

//--- verification/sdr_field_model.sv
// field side model: wipers, switches, sector and encoder pins
`timescale 1ns/1ps
module sdr_field_model
    import sdr_pkg::*;
(
    // clock
    input wire logic mclk,
    // sensor side
    output sdr_pkg::sdr_adc_t adc,
    output logic [1:0] sector,
    output logic cw_pin_n,
    output logic ccw_pin_n,
    output logic straight_ahead_switch,
    output logic travel_pin,
    output logic enc_step,
    output logic enc_dir
);
    // pull-ups hold open switches high; encoder stays parked
    initial
    begin
        adc = {10'h111, 10'h222, 10'h100, 10'h333};
        sector = 2'h0;
        cw_pin_n = 1'b1;
        ccw_pin_n = 1'b1;
        straight_ahead_switch = 1'b1;
        travel_pin = 1'b0;
        enc_step = 1'b0;
        enc_dir = 1'b0;
    end

    // wipers only move on a clock edge
    task automatic set_adc(input sdr_adc_t v);
        @(posedge mclk);
        adc <= v;
    endtask : set_adc

    task automatic set_pins(input logic cw, input logic ccw, input logic sa,
        input logic tr, input logic [1:0] sec);
        @(posedge mclk);
        cw_pin_n <= cw;
        ccw_pin_n <= ccw;
        straight_ahead_switch <= sa;
        travel_pin <= tr;
        sector <= sec;
    endtask : set_pins

    // one count per rising edge, slow enough for the pin synchroniser
    task automatic step_enc(input int n, input logic dn);
        @(posedge mclk);
        enc_dir <= dn;
        repeat (n)
        begin
            repeat (2) @(posedge mclk);
            enc_step <= 1'b1;
            repeat (2) @(posedge mclk);
            enc_step <= 1'b0;
        end
    endtask : step_enc
endmodule : sdr_field_model

//--- verification/steering_diagnostic_readout_tb_top.sv
// self-checking bench of the steering diagnostic readout
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    n_errors++; $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module steering_diagnostic_readout_tb_top;
    import sdr_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    sdr_adc_t adc, a;
    sdr_alarm_t alarm_raw = 4'hF;
    sdr_alarm_t alarm_out;
    logic [9:0] fb_pos = 10'h200;
    logic key_on = 1'b1;
    logic bus_travel = 1'b1;
    logic [1:0] sector;
    logic cw_n, ccw_n, sa_sw, travel_pin, enc_step, enc_dir;
    logic idle_act, acq_act, jerk, cmd_fault;
    logic [9:0] sp;
    logic [7:0] flux = 8'hFF;
    logic [9:0] exp_ctr = 10'h155;
    logic hint;
    logic [3:0] am [4] = '{4'h5, 4'h4, 4'h9, 4'h8};
    logic [3:0] sels [3] = '{SEL_DEFAULT, SEL_FINE_ROUTE, SEL_SECOND_WIPER};
    logic [9:0] spx [3] = '{10'h111, 10'h333, 10'h222};
    logic [9:0] qx [4] = '{QUAD_0_90, QUAD_90_180, QUAD_M180_M90, QUAD_M90_0};
    logic [31:0] lc [5] = '{32'h12F, 32'h12F, 32'h2F, 32'h99008F, 32'h98008F};
    logic [9:0] lp [5] = '{10'h350, 10'h050, 10'h350, 10'h350, 10'h050};
    logic [31:0] lx [5] = '{32'h10, 32'h20, 32'h0, 32'h0, 32'h20};
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    sdr_field_model i_field (.mclk(mclk), .adc(adc), .sector(sector),
        .cw_pin_n(cw_n), .ccw_pin_n(ccw_n), .straight_ahead_switch(sa_sw),
        .travel_pin(travel_pin), .enc_step(enc_step), .enc_dir(enc_dir));

    sdr_readout #(.SLOPE_TICKS(16)) i_dut (.mclk(mclk), .srst(srst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .adc(adc), .alarm_raw(alarm_raw),
        .nominal_saturation_frequency(16'h1234), .flux_level(flux),
        .feedback_position_reading(fb_pos), .upper_limit(10'h300),
        .lower_limit(10'h100), .sector(sector),
        .expected_pot_at_center(exp_ctr), .key_on(key_on),
        .bus_travel(bus_travel), .cw_pin_n(cw_n), .ccw_pin_n(ccw_n),
        .straight_ahead_switch(sa_sw), .travel_pin(travel_pin),
        .enc_step(enc_step), .enc_dir(enc_dir), .alarm_out(alarm_out),
        .idle_test_active(idle_act), .acquire_active(acq_act),
        .set_point_reading(sp), .feedback_pot_jerk_alarm(jerk),
        .command_pot_fault_alarm(cmd_fault), .mismatch_hint(hint));

    initial
    begin
        forever #2 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // register port and checking tasks
    // ------------------------------------------------------------------
    task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic chk_reg(input logic [7:0] ad, input logic [31:0] m,
        input logic [31:0] e, input string nm);
        addr <= ad;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
        `CHK(nm, e, rdata & m)
    endtask : chk_reg

    // step the wipers, watch a flag, then check the held peak
    task automatic slope_case(input sdr_adc_t v, input logic [10:0] pk,
        input logic w, input logic ef);
        logic s;
        s = 1'b0;
        repeat (48) @(posedge mclk);
        chk_reg(ADDR_SLOPE, 32'h7FF, 32'h0, "clear");
        i_field.set_adc(v);
        repeat (48)
        begin
            @(posedge mclk);
            if ((w ? cmd_fault : jerk) === 1'b1)
                s = 1'b1;
        end
        `CHK("alarm seen", ef, s)
        chk_reg(ADDR_SLOPE, 32'h07FF_0000, {5'h0, pk, 16'h0}, "peak");
    endtask : slope_case

    task automatic final_report;
        if (n_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_errors++;
            final_report();
        end
    end

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        a = adc;
        chk_reg(ADDR_CTRL, 32'hFFFF_FFFF, CTRL_RESET, "ctrl");
        chk_reg(ADDR_THRESH, 32'hF, 32'h9, "level");
        wr_reg(ADDR_CTRL, 32'h5);
        `CHK("reserved", {4'hF, 1'b0, 1'b0}, {alarm_out, acq_act, idle_act})
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(ADDR_CTRL, {18'h0, i[0], 9'h0,
                i[1] ? SEL_ALARM_KEY : SEL_ALARM_HOLD});
            `CHK("mask", am[i], alarm_out)
        end
        // key cycle returns the selector to default
        key_on <= 1'b0;
        repeat (6) @(posedge mclk);
        key_on <= 1'b1;
        repeat (6) @(posedge mclk);
        chk_reg(ADDR_CTRL, 32'hF, 32'hF, "key revert");
        wr_reg(ADDR_CTRL, 32'h0);
        `CHK("acquire", 1'b1, acq_act)
        wr_reg(ADDR_LIMITS, 32'h0);
        chk_reg(ADDR_CTRL, 32'hF, 32'hF, "acq revert");
        wr_reg(ADDR_CTRL, 32'hA);
        wr_reg(ADDR_CTRL, 32'hF);
        `CHK("idle unsaved", 1'b1, idle_act)
        wr_reg(ADDR_CTRL, 32'h1F);
        `CHK("idle saved", 1'b0, idle_act)
        for (int i = 0; i < 3; i++)
        begin
            wr_reg(ADDR_CTRL, {28'h0, sels[i]});
            @(posedge mclk);
            `CHK("setpoint", spx[i], sp)
            chk_reg(ADDR_STATUS, 32'h100, {23'h0, i == 1, 8'h0}, "fine");
        end
        wr_reg(ADDR_CTRL, 32'h100F);
        i_field.set_pins(1'b0, 1'b1, 1'b1, 1'b1, 2'h0);
        repeat (6) @(posedge mclk);
        chk_reg(ADDR_STATUS, 32'hCC, 32'hC4, "pins");
        wr_reg(ADDR_CTRL, 32'h20F);
        bus_travel <= 1'b0;
        i_field.set_pins(1'b1, 1'b0, 1'b1, 1'b1, 2'h0);
        repeat (6) @(posedge mclk);
        chk_reg(ADDR_STATUS, 32'hCC, 32'h08, "bus");
        for (int i = 0; i < 5; i++)
        begin
            wr_reg(ADDR_CTRL, lc[i]);
            fb_pos <= lp[i];
            chk_reg(ADDR_STATUS, 32'h30, lx[i], "limits");
        end
        wr_reg(ADDR_CTRL, 32'h200F);
        for (int i = 0; i < 4; i++)
        begin
            i_field.set_pins(1'b1, 1'b1, 1'b1, 1'b0, i[1:0]);
            chk_reg(ADDR_QUAD, 32'h3FF, {22'h0, qx[i]}, "quadrant");
        end
        chk_reg(ADDR_FLUX, 32'hFFFF, 32'h1234, "flux");
        flux <= 8'h00;
        chk_reg(ADDR_FLUX, 32'h3FFFF, 32'h1845, "flux light");
        wr_reg(ADDR_CTRL, 32'hD);
        a.feedback = 10'h13D;
        slope_case(a, 11'h03D, 1'b0, 1'b0);
        a.feedback = 10'h17B;
        slope_case(a, 11'h03E, 1'b0, 1'b1);
        wr_reg(ADDR_THRESH, 32'h0);
        wr_reg(ADDR_CTRL, 32'hC);
        a.secondary = 10'h22A;
        slope_case(a, 11'h008, 1'b1, 1'b0);
        wr_reg(ADDR_CTRL, 32'hF);
        a.primary = 10'h14F;
        slope_case(a, 11'h03E, 1'b1, 1'b1);
        // capture holds the first falling edge only
        wr_reg(ADDR_CTRL, 32'h6F);
        a.feedback = 10'h155;
        i_field.set_adc(a);
        i_field.set_pins(1'b1, 1'b1, 1'b0, 1'b0, 2'h0);
        repeat (6) @(posedge mclk);
        chk_reg(ADDR_CAPTURE, 32'h3FF, 32'h155, "capture");
        a.feedback = 10'h0AA;
        i_field.set_adc(a);
        i_field.set_pins(1'b1, 1'b1, 1'b1, 1'b0, 2'h0);
        i_field.set_pins(1'b1, 1'b1, 1'b0, 1'b0, 2'h0);
        repeat (6) @(posedge mclk);
        chk_reg(ADDR_CAPTURE, 32'h3FF, 32'h155, "recapture");
        `CHK("hint", 1'b0, hint)
        exp_ctr <= 10'h156;
        @(posedge mclk);
        `CHK("hint set", 1'b1, hint)
        // arm on one falling edge, count, close on the next
        wr_reg(ADDR_CTRL, 32'h8F);
        i_field.set_pins(1'b1, 1'b1, 1'b1, 1'b0, 2'h0);
        repeat (4) @(posedge mclk);
        i_field.set_pins(1'b1, 1'b1, 1'b0, 1'b0, 2'h0);
        repeat (4) @(posedge mclk);
        i_field.step_enc(64, 1'b0);
        i_field.set_pins(1'b1, 1'b1, 1'b1, 1'b0, 2'h0);
        repeat (4) @(posedge mclk);
        i_field.set_pins(1'b1, 1'b1, 1'b0, 1'b0, 2'h0);
        repeat (4) @(posedge mclk);
        i_field.step_enc(3, 1'b0);
        repeat (4) @(posedge mclk);
        chk_reg(ADDR_REVS, 32'hFFFF, 32'h2, "revs");
        chk_reg(ADDR_ANGLE, 32'hFFFF, 32'h3, "angle");
        final_report();
    end
endmodule : steering_diagnostic_readout_tb_top
